// ==== common/stwc_pkg.sv ====
// Package with register map, field layouts and timing constants
package stwc_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OUTPUT_ENABLE_CONTROL_OFS = 8'h00;
  localparam logic [7:0] CHANNEL_START_TRIGGER_OFS = 8'h04;
  localparam logic [7:0] SERIAL_MODE_SETUP_OFS = 8'h08;
  localparam logic [7:0] SHIFT_DATA_AND_DIVISOR_OFS = 8'h0C;
  localparam logic [7:0] CLOCK_OUTPUT_LEVEL_OFS = 8'h10;
  localparam logic [7:0] DATA_OUTPUT_LEVEL_OFS = 8'h14;
  localparam logic [7:0] COMM_SETTING_REG_OFS = 8'h18;
  localparam logic [7:0] CHANNEL_STATUS_OFS = 8'h1C;
  localparam logic [7:0] FLAG_CLEAR_OFS = 8'h20;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CHAN_BIT = 0;
  localparam int TRANSMIT_ENABLE_POS = 15;
  localparam int RECEIVE_ENABLE_POS = 14;
  localparam int DIV_LSB = 9;
  localparam int DIV_MSB = 15;
  localparam int STAT_BUSY_POS = 6;
  localparam int STAT_ACK_ERR_POS = 1;
  localparam int STAT_IRQ_POS = 0;
  // ---------------------------------------------------------------
  // Reset values and frame counts
  // ---------------------------------------------------------------
  localparam logic [15:0] SERIAL_MODE_SETUP_RST = 16'h0020;
  localparam logic [15:0] COMM_SETTING_RST = 16'h0087;
  localparam logic [15:0] SHIFT_DATA_RST = 16'h0000;
  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [6:0] DIV_MIN = 7'h01;
  localparam logic [31:0] APB_UNMAPPED_RDATA = 32'h0000_0000;
endpackage : stwc_pkg

// ==== common/stwc_shift_if.sv ====
// Interface between the register file and the frame shifter
`timescale 1ns/1ps
interface stwc_shift_if;
  logic start;
  logic [7:0] tx_byte;
  logic [6:0] divisor;
  logic busy;
  logic done;
  logic ack_err;
  logic sda_out;
  logic scl_out;
  modport ctrl (output start, output tx_byte, output divisor, input busy, input done, input ack_err,
    input sda_out, input scl_out);
  modport shifter (input start, input tx_byte, input divisor, output busy, output done, output ack_err,
    output sda_out, output scl_out);
endinterface : stwc_shift_if

// ==== rtl/stwc_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module stwc_sync (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Data
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_q <= 1'b1;
      o_sync <= 1'b1;
    end else if (i_ce) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : stwc_sync

// ==== rtl/stwc_shifter.sv ====
// Frame shifter: 8 bits MSB first plus acknowledge slot, 50% duty clock
`timescale 1ns/1ps
module stwc_shifter
  import stwc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Synchronised data line
  input wire logic i_sda_sync,
  // Control link
  stwc_shift_if.shifter sh
);
  typedef enum logic [2:0] {
    STWC_IDLE = 3'b001,
    STWC_LOW = 3'b010,
    STWC_HIGH = 3'b100
  } stwc_state_e;

  stwc_state_e state_q;
  logic [6:0] tick_q;
  logic [3:0] bit_q;
  logic [7:0] sreg_q;
  logic half_end;
  logic done_q;
  logic ackerr_q;

  // half period of divisor plus one
  assign half_end = (tick_q == sh.divisor);
  assign sh.busy = (state_q != STWC_IDLE);
  assign sh.done = done_q;
  assign sh.ack_err = ackerr_q;
  // MSB first, released high during the acknowledge slot
  assign sh.sda_out = (bit_q == ACK_SLOT) ? 1'b1 : sreg_q[7];
  assign sh.scl_out = (state_q != STWC_LOW);

  // ---------------------------------------------------------------
  // Bit timing
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= STWC_IDLE;
      tick_q <= 7'h00;
      bit_q <= 4'h0;
      sreg_q <= 8'hFF;
    end else if (i_ce) begin
      unique case (state_q)
        STWC_IDLE: begin
          tick_q <= 7'h00;
          if (sh.start) begin
            sreg_q <= sh.tx_byte;
            bit_q <= 4'h0;
            state_q <= STWC_LOW;
          end
        end
        STWC_LOW: begin
          tick_q <= half_end ? 7'h00 : tick_q + 7'h01;
          if (half_end) begin
            state_q <= STWC_HIGH;
          end
        end
        STWC_HIGH: begin
          tick_q <= half_end ? 7'h00 : tick_q + 7'h01;
          if (half_end) begin
            // eight data bits then one acknowledge slot, no parity
            if (bit_q == ACK_SLOT) begin
              state_q <= STWC_IDLE;
              bit_q <= 4'h0;
            end else begin
              bit_q <= bit_q + 4'h1;
              sreg_q <= {sreg_q[6:0], 1'b1};
              state_q <= STWC_LOW;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // End of frame and acknowledge sampling
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      done_q <= 1'b0;
      ackerr_q <= 1'b0;
    end else if (i_ce) begin
      done_q <= (state_q == STWC_HIGH) && half_end && (bit_q == ACK_SLOT);
      ackerr_q <= 1'b0;
      // high data line in acknowledge slot is an error
      if ((state_q == STWC_HIGH) && half_end && (bit_q == ACK_SLOT)) begin
        ackerr_q <= i_sda_sync;
      end
    end
  end

  // AST_FRAME_DONE_IDLE
  AST_FRAME_DONE_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && done_q |-> state_q == STWC_IDLE)
    else $error("done pulse outside idle");
  // AST_SCL_HIGH_IN_IDLE
  AST_SCL_HIGH_IN_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_q == STWC_IDLE |-> sh.scl_out && sh.sda_out)
    else $error("bus not released in idle");
  // AST_ACK_SLOT_RELEASED
  AST_ACK_SLOT_RELEASED: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_q != STWC_IDLE |-> bit_q <= ACK_SLOT && (bit_q != ACK_SLOT || sh.sda_out))
    else $error("data driven in acknowledge slot");
  // AST_HALF_PERIOD
  AST_HALF_PERIOD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && state_q == STWC_LOW && half_end |=> state_q == STWC_HIGH && tick_q == 7'h00)
    else $error("low phase not followed by high phase");
  // AST_MSB_FIRST
  AST_MSB_FIRST: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && state_q == STWC_IDLE && sh.start |=> sh.sda_out == $past(sh.tx_byte[7]))
    else $error("first bit is not the MSB");
endmodule : stwc_shifter

// ==== rtl/stwc_channel.sv ====
// Simple two-wire channel: APB registers, start control and pin drive
`timescale 1ns/1ps
// How it works
// - After software start, address and direction go out as one frame.
// - Address frame is 8 bits: 7 address bits, direction in bit 0.
// - Only the transfer-end event is flagged; no buffer-empty source exists.
// - The only transmit error reported is the acknowledge error flag.
// - Clock is at most a quarter of operation clock; divisor must be >=1.
// - Data is not inverted, idles high, and shifts MSB first.
// - No parity; one acknowledge slot follows the eighth bit.
// - During transfer the low byte is data, the high byte the divisor.
// - After the address, 8-bit data frames follow; then stop and release.
// - Bit rate is operation clock over divisor plus one, halved.
// - Serial clock has equal high and low phases.
module stwc_channel
  import stwc_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Two-wire pins
  input wire logic i_bus_clock_pin,
  output logic o_bus_clock_pin,
  output logic o_bus_clock_pin_oe,
  input wire logic i_bus_data_pin,
  output logic o_bus_data_pin,
  output logic o_bus_data_pin_oe,
  // Events
  output logic o_transfer_end_irq
);
  stwc_shift_if sh ();

  logic [7:0] oe_ctrl_q;
  logic [15:0] mode_q;
  logic [15:0] sdr_q;
  logic [7:0] cko_q;
  logic [7:0] so_q;
  logic [15:0] scr_q;
  logic ack_error_flag_q;
  logic irq_q;
  logic sda_sync;
  logic scl_sync;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic start_req;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  assign wr_en = i_ce && i_psel && i_penable && i_pwrite;
  assign rd_en = i_ce && i_psel && !i_penable && !i_pwrite;
  assign mapped = addr_is(i_paddr, OUTPUT_ENABLE_CONTROL_OFS) || addr_is(i_paddr, CHANNEL_START_TRIGGER_OFS)
    || addr_is(i_paddr, SERIAL_MODE_SETUP_OFS) || addr_is(i_paddr, SHIFT_DATA_AND_DIVISOR_OFS)
    || addr_is(i_paddr, CLOCK_OUTPUT_LEVEL_OFS) || addr_is(i_paddr, DATA_OUTPUT_LEVEL_OFS)
    || addr_is(i_paddr, COMM_SETTING_REG_OFS) || addr_is(i_paddr, CHANNEL_STATUS_OFS)
    || addr_is(i_paddr, FLAG_CLEAR_OFS);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_prdata = prdata_q;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  stwc_sync u_sync_sda (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_bus_data_pin),
    .o_sync(sda_sync)
  );

  stwc_sync u_sync_scl (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_bus_clock_pin),
    .o_sync(scl_sync)
  );

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      oe_ctrl_q <= 8'h00;
      mode_q <= SERIAL_MODE_SETUP_RST;
      cko_q <= 8'hFF;
      so_q <= 8'hFF;
      scr_q <= COMM_SETTING_RST;
    end else if (wr_en) begin
      if (addr_is(i_paddr, COMM_SETTING_REG_OFS)) begin
        // only enable bits move while busy
        if (sh.busy) begin
          scr_q[TRANSMIT_ENABLE_POS] <= i_pwdata[TRANSMIT_ENABLE_POS];
          scr_q[RECEIVE_ENABLE_POS] <= i_pwdata[RECEIVE_ENABLE_POS];
        end else begin
          scr_q <= i_pwdata[15:0];
        end
      end
      // mode, clock, output and enable frozen while busy
      if (!sh.busy) begin
        if (addr_is(i_paddr, OUTPUT_ENABLE_CONTROL_OFS)) begin
          oe_ctrl_q <= i_pwdata[7:0];
        end
        if (addr_is(i_paddr, SERIAL_MODE_SETUP_OFS)) begin
          mode_q <= i_pwdata[15:0];
        end
        if (addr_is(i_paddr, CLOCK_OUTPUT_LEVEL_OFS)) begin
          cko_q <= i_pwdata[7:0];
        end
        if (addr_is(i_paddr, DATA_OUTPUT_LEVEL_OFS)) begin
          so_q <= i_pwdata[7:0];
        end
      end
    end
  end

  // low byte data, high byte divisor
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sdr_q <= SHIFT_DATA_RST;
    end else if (wr_en && addr_is(i_paddr, SHIFT_DATA_AND_DIVISOR_OFS)) begin
      if (sh.busy) begin
        sdr_q[7:0] <= i_pwdata[7:0];
      end else begin
        sdr_q <= i_pwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Start trigger
  // ---------------------------------------------------------------
  // start sends the address and direction frame
  // later starts send data frames from the same register
  assign start_req = wr_en && addr_is(i_paddr, CHANNEL_START_TRIGGER_OFS) && i_pwdata[CHAN_BIT]
    && !sh.busy && i_pwdata[TRANSMIT_ENABLE_POS - 8] == 1'b0 && scr_q[TRANSMIT_ENABLE_POS];

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sh.start <= 1'b0;
      sh.tx_byte <= 8'hFF;
      sh.divisor <= DIV_MIN;
    end else if (i_ce) begin
      sh.start <= start_req;
      if (start_req) begin
        // upper 7 bits address, bit 0 direction
        sh.tx_byte <= sdr_q[7:0];
        // divisor of zero is forced to the minimum of one
        sh.divisor <= (sdr_q[DIV_MSB:DIV_LSB] < DIV_MIN) ? DIV_MIN : sdr_q[DIV_MSB:DIV_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ack_error_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (i_ce) begin
      // acknowledge error is the only error flag; set wins over clear
      if (sh.ack_err) begin
        ack_error_flag_q <= 1'b1;
      end else if (wr_en && addr_is(i_paddr, FLAG_CLEAR_OFS) && i_pwdata[STAT_ACK_ERR_POS]) begin
        ack_error_flag_q <= 1'b0;
      end
      // transfer end is the only event
      irq_q <= sh.done;
    end
  end

  assign o_transfer_end_irq = irq_q;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = APB_UNMAPPED_RDATA;
    if (addr_is(i_paddr, OUTPUT_ENABLE_CONTROL_OFS)) begin
      rdata_d = {24'h000000, oe_ctrl_q};
    end else if (addr_is(i_paddr, SERIAL_MODE_SETUP_OFS)) begin
      rdata_d = {16'h0000, mode_q};
    end else if (addr_is(i_paddr, SHIFT_DATA_AND_DIVISOR_OFS)) begin
      rdata_d = {16'h0000, sdr_q};
    end else if (addr_is(i_paddr, CLOCK_OUTPUT_LEVEL_OFS)) begin
      rdata_d = {24'h000000, cko_q};
    end else if (addr_is(i_paddr, DATA_OUTPUT_LEVEL_OFS)) begin
      rdata_d = {24'h000000, so_q};
    end else if (addr_is(i_paddr, COMM_SETTING_REG_OFS)) begin
      rdata_d = {16'h0000, scr_q};
    end else if (addr_is(i_paddr, CHANNEL_STATUS_OFS)) begin
      // Synchronised line levels let software see a held bus
      rdata_d = {24'h000000, 1'b0, sh.busy, 2'h0, scl_sync, sda_sync, ack_error_flag_q, irq_q};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  stwc_shifter u_shifter (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_sda_sync(sda_sync),
    .sh(sh)
  );

  logic sda_level;
  logic scl_level;
  // shifter drives data while enabled, else software level
  assign sda_level = oe_ctrl_q[CHAN_BIT] ? sh.sda_out : so_q[CHAN_BIT];
  assign scl_level = sh.busy ? sh.scl_out : cko_q[CHAN_BIT];
  // Open drain: only low levels are driven
  assign o_bus_data_pin = 1'b0;
  assign o_bus_data_pin_oe = !sda_level;
  assign o_bus_clock_pin = 1'b0;
  assign o_bus_clock_pin_oe = !scl_level;

  // AST_ACK_FLAG_SET
  AST_ACK_FLAG_SET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && sh.ack_err |=> ack_error_flag_q)
    else $error("acknowledge error not flagged");
  // AST_IRQ_FOLLOWS_DONE
  AST_IRQ_FOLLOWS_DONE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_ce && sh.done |=> o_transfer_end_irq)
    else $error("transfer end not raised");
  // AST_MODE_FROZEN
  AST_MODE_FROZEN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    sh.busy ##1 sh.busy |-> $stable(mode_q) && $stable(oe_ctrl_q))
    else $error("mode changed during transfer");
  // AST_DIV_MIN
  AST_DIV_MIN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    sh.busy |-> sh.divisor >= DIV_MIN)
    else $error("divisor below one");
  // AST_DIVISOR_FROZEN
  AST_DIVISOR_FROZEN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    sh.busy ##1 sh.busy |-> $stable(sdr_q[15:8]))
    else $error("divisor changed during transfer");
endmodule : stwc_channel

// ==== tb/stwc_slave_model.sv ====
// Behavioural two-wire slave that collects bytes and answers the acknowledge slot
`timescale 1ns/1ps
module stwc_slave_model (
  // Bus wires
  input wire logic i_scl,
  input wire logic i_sda,
  // Control and capture
  input wire logic i_nack,
  output logic o_sda_oe,
  output logic [7:0] o_byte,
  output logic [3:0] o_bits
);
  initial begin
    o_sda_oe = 1'b0;
    o_byte = 8'h00;
    o_bits = 4'h0;
  end
  // ---------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------
  // Start condition restarts the bit count
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      o_bits = 4'h0;
    end
  end
  always @(posedge i_scl) begin
    if (o_bits < 4'h8) begin
      o_byte = {o_byte[6:0], i_sda};
    end
    o_bits = o_bits + 4'h1;
  end
  always @(negedge i_scl) begin
    if (o_bits == 4'h8) begin
      o_sda_oe = ~i_nack;
    end else if (o_bits == 4'h9) begin
      o_sda_oe = 1'b0;
      o_bits = 4'h0;
    end
  end
endmodule : stwc_slave_model

// ==== tb/stwc_channel_tb_top.sv ====
// Self-checking bench for the simple two-wire channel
`timescale 1ns/1ps
module stwc_channel_tb_top;
  import stwc_pkg::*;
  logic i_sys_clk, i_rst, psel, penable, pwrite, nack, scl_prev, slverr;
  logic pready, pslverr, irq, clk_oe, sda_oe, slv_oe, scl_w, sda_w, ce, pin_c, pin_d;
  logic [7:0] paddr, fb, slv_byte;
  logic [6:0] dv;
  logic [3:0] slv_bits;
  logic [31:0] pwdata, prdata, rd, lfsr_q;
  int n_mismatch, checks_done, edge_n, run, ph, bad_ph;
  logic [7:0] rst_addr [5] = '{SERIAL_MODE_SETUP_OFS, SHIFT_DATA_AND_DIVISOR_OFS, CLOCK_OUTPUT_LEVEL_OFS,
    DATA_OUTPUT_LEVEL_OFS, COMM_SETTING_REG_OFS};
  logic [31:0] rst_val [5] = '{{16'h0, SERIAL_MODE_SETUP_RST}, {16'h0, SHIFT_DATA_RST}, 32'h0000_00FF,
    32'h0000_00FF, {16'h0, COMM_SETTING_RST}};
  // ---------------------------------------------------------------
  // Clock, design and partner
  // ---------------------------------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  assign scl_w = ~clk_oe;
  assign sda_w = ~(sda_oe | slv_oe);
  stwc_channel dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_bus_clock_pin(scl_w), .o_bus_clock_pin(pin_c), .o_bus_clock_pin_oe(clk_oe),
    .i_bus_data_pin(sda_w), .o_bus_data_pin(pin_d), .o_bus_data_pin_oe(sda_oe), .o_transfer_end_irq(irq));
  stwc_slave_model slave (.i_scl(scl_w), .i_sda(sda_w), .i_nack(nack), .o_sda_oe(slv_oe), .o_byte(slv_byte),
    .o_bits(slv_bits));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic int phase_len(input logic [6:0] div);
    phase_len = (div == 7'h00) ? 2 : int'(div) + 1;
  endfunction : phase_len
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    @(posedge i_sys_clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 16) chk(32'h0, 32'h1, "no ready");
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Clock phase lengths seen on the wire, first edge follows idle
  always @(negedge i_sys_clk) begin
    if (scl_w !== scl_prev) begin
      edge_n++;
      if (edge_n >= 2 && run != ph) bad_ph++;
      run = 1;
    end else begin
      run++;
    end
    scl_prev = scl_w;
  end
  task automatic send_frame(input logic [7:0] b, input logic [6:0] div, input logic nk);
    int n;
    n = 0;
    apb(1'b1, SHIFT_DATA_AND_DIVISOR_OFS, {16'h0, div, 1'b0, b});
    nack <= nk;
    ph = phase_len(div);
    edge_n = 0;
    bad_ph = 0;
    apb(1'b1, CHANNEL_START_TRIGGER_OFS, 32'h0000_0001);
    apb(1'b0, CHANNEL_STATUS_OFS, 32'h0);
    chk(rd & 32'h40, 32'h40, "busy");
    // mid frame writes: only the data byte and the comm enable bits may change
    apb(1'b1, SHIFT_DATA_AND_DIVISOR_OFS, {16'h0, 7'h7F, 1'b0, b});
    apb(1'b0, SHIFT_DATA_AND_DIVISOR_OFS, 32'h0);
    chk(rd & 32'hFEFF, {16'h0, div, 1'b0, b}, "divisor held");
    apb(1'b1, SERIAL_MODE_SETUP_OFS, 32'h0000_1234);
    apb(1'b1, COMM_SETTING_REG_OFS, 32'h0000_C000);
    while (irq !== 1'b1 && n < 4000) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1, "end event");
    @(negedge i_sys_clk);
    chk({31'h0, irq}, 32'h0, "event pulse");
    chk({24'h0, slv_byte}, {24'h0, b}, "byte on wire");
    chk({28'h0, slv_bits}, 32'h9, "bit slots");
    chk(32'(edge_n), 32'h12, "clock edges");
    chk(32'(bad_ph), 32'h0, "phase length");
    apb(1'b0, CHANNEL_STATUS_OFS, 32'h0);
    chk(rd & 32'h42, nk ? 32'h2 : 32'h0, "status");
    apb(1'b0, SERIAL_MODE_SETUP_OFS, 32'h0);
    chk(rd, {16'h0, SERIAL_MODE_SETUP_RST}, "mode held");
    apb(1'b0, COMM_SETTING_REG_OFS, 32'h0);
    chk(rd, {16'h0, 2'b11, COMM_SETTING_RST[13:0]}, "comm enables only");
    if (nk) begin
      apb(1'b1, FLAG_CLEAR_OFS, 32'h2);
      apb(1'b0, CHANNEL_STATUS_OFS, 32'h0);
      chk(rd & 32'h2, 32'h0, "flag clear");
    end
  endtask : send_frame
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    n_mismatch++;
    $display("BAD t=%0t watchdog expired", $time);
    conclude();
  end
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    i_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nack = 1'b0;
    ce = 1'b1;
    lfsr_q = 32'h3B45;
    scl_prev = 1'b1;
    run = 0;
    edge_n = 0;
    ph = 2;
    bad_ph = 0;
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(negedge i_sys_clk);
    chk({30'h0, scl_w, sda_w}, 32'h3, "idle lines");
    chk({30'h0, pin_c, pin_d}, 32'h0, "pins drive low only");
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, rst_addr[i], 32'h0);
      chk(rd, rst_val[i], "reset value");
    end
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, APB_UNMAPPED_RDATA, "unmapped data");
    chk({31'h0, slverr}, 32'h1, "unmapped error");
    // Clock enable low must freeze register writes
    ce <= 1'b0;
    apb(1'b1, SERIAL_MODE_SETUP_OFS, 32'h0000_1234);
    ce <= 1'b1;
    apb(1'b0, SERIAL_MODE_SETUP_OFS, 32'h0);
    chk(rd, {16'h0, SERIAL_MODE_SETUP_RST}, "frozen write");
    apb(1'b1, CHANNEL_START_TRIGGER_OFS, 32'h0000_0001);
    apb(1'b0, CHANNEL_STATUS_OFS, 32'h0);
    chk(rd & 32'h40, 32'h0, "start without enable");
    chk(rd & 32'hC, 32'hC, "line levels");
    $display("test reset and refusal done");
    // enable, start condition, then output enable
    apb(1'b1, COMM_SETTING_REG_OFS, {16'h0, 1'b1, COMM_SETTING_RST[14:0]});
    apb(1'b1, DATA_OUTPUT_LEVEL_OFS, 32'h0000_00FE);
    apb(1'b1, OUTPUT_ENABLE_CONTROL_OFS, 32'h0000_0001);
    for (int k = 0; k < 6; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      fb = (k == 0) ? {lfsr_q[7:1], 1'b0} : lfsr_q[7:0];
      // Divisor zero is the forced-minimum corner; others keep the clock under fast-mode limit
      dv = (k == 1) ? 7'h00 : 7'h18 + {4'h0, lfsr_q[10:8]};
      send_frame(fb, dv, k == 3);
      $display("test frame %0d done", k);
    end
    apb(1'b1, OUTPUT_ENABLE_CONTROL_OFS, 32'h0);
    apb(1'b1, CLOCK_OUTPUT_LEVEL_OFS, 32'h0000_00FE);
    apb(1'b1, CLOCK_OUTPUT_LEVEL_OFS, 32'h0000_00FF);
    apb(1'b1, DATA_OUTPUT_LEVEL_OFS, 32'h0000_00FF);
    @(negedge i_sys_clk);
    chk({30'h0, scl_w, sda_w}, 32'h3, "bus released");
    $display("test stop done");
    conclude();
  end
endmodule : stwc_channel_tb_top
